// [logic/repeater_lane_config_rx_detect.sv]
// Summary of operation
// RULE1 - Both eq selects floating give gain stage 00, boost 000, bypass.
// RULE2 - Eq selects both high give gain stage 01, boost 010.
// RULE3 - Gain stage 10: LL 000, FL 010, FH 101, LH 111.
// RULE4 - Eq high pin high, low pin low give gain 11, boost 001.
// RULE5 - Gain stage 11: low/float boost 011, high/float boost 101.
// RULE6 - Pulse width 400ps at gen1, 200ps at gen2; both low is 0dB.
// RULE7 - Select 01 gives -3.5dB, 10 gives -6dB, 1000mV swing.
// RULE8 - Select 11 -6dB enhanced, 0F -9dB enhanced, 1F -12dB enhanced.
// RULE9 - F0 -9dB enhanced 1200mV, F1 -12dB enhanced 1400mV, FF reserved.
// RULE10 - Floating rate pin enables automatic rate detection.
// RULE11 - In register mode software programs de-emphasis via registers.
// RULE12 - Idle control low disables idle detection; output follows input.
// RULE13 - Idle control floating squelches output below idle threshold.
// RULE14 - Idle control high forces output idle, ignoring inputs.
// RULE15 - Auto detect, request low: probe every 12 ms until found.
// RULE16 - Request high: probe for 600 ms then stop; rising edge restarts.
// RULE17 - Manual enable, request low: detector off, high-Z, outputs idle.
// RULE18 - Manual enable, request high: detector off, 50 ohm, outputs on.
// RULE19 - Power-down request forces high-Z, outputs off, power saving.
// RULE20 - Power-down request must be held at least 5 us.
// RULE21 - Falling edge of power-down request restarts auto detection.
// RULE22 - Detection needs valid load on both halves of each pair.
// RULE23 - Register mode moves rate, eq and de-emphasis to registers.
// RULE24 - Auto rate re-detected after every exit from electrical idle.
// RULE25 - Register values reset when register mode deselected.
// RULE26 - Pins resolve to low, high, float; settings apply to all lanes.
`timescale 1ns/1ps
`default_nettype none
`include "repeater_defs.svh"
module repeater_lane_config_rx_detect #(
  parameter int LANES = 4,
  parameter int POLL_CYCLES =
    (`POLL_PERIOD_US * 1000) / (`CLK_PERIOD_PS / 1000),
  parameter int POLL_COUNT = `POLL_WINDOW_MS * 1000 / `POLL_PERIOD_US
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire repeater_pkg::tri_pin_t eq_select_low_in,
  input wire repeater_pkg::tri_pin_t eq_select_high_in,
  input wire repeater_pkg::tri_pin_t deemph_select_low_in,
  input wire repeater_pkg::tri_pin_t deemph_select_high_in,
  input wire repeater_pkg::tri_pin_t rate_in,
  input wire repeater_pkg::tri_pin_t idle_control_in,
  input wire logic register_mode_select_in,
  input wire repeater_pkg::eq_cfg_t reg_eq_in,
  input wire repeater_pkg::de_cfg_t reg_de_in,
  input wire logic reg_rate_gen2_in,
  input wire logic detected_gen2_in,
  input wire logic input_idle_in,
  input wire logic power_down_request_in,
  input wire logic manual_termination_enable_in,
  input wire logic termination_request_in,
  input wire logic [LANES-1:0] load_pos_in,
  input wire logic [LANES-1:0] load_neg_in,
  output repeater_pkg::eq_cfg_t eq_cfg_out [LANES],
  output repeater_pkg::de_cfg_t de_cfg_out [LANES],
  output logic [LANES-1:0] output_idle_out,
  output logic [LANES-1:0] output_enable_out,
  output logic [LANES-1:0] term_50_out,
  output logic idle_detect_enable_out,
  output logic probe_out,
  output logic power_save_out,
  output logic regs_reset_out
);
  localparam int PCW = $clog2(POLL_CYCLES + 1);
  localparam int NCW = $clog2(POLL_COUNT + 1);

  if (LANES < 1 || POLL_CYCLES < 2 || POLL_COUNT < 1) begin : g_bad_params
    $error("repeater: bad parameters");
  end

  function automatic repeater_pkg::tri_t resolve(
      input repeater_pkg::tri_pin_t p);
    if (p.pin_high && p.pin_low) begin
      resolve = repeater_pkg::TRI_HIGH;
    end else if (!p.pin_high && !p.pin_low) begin
      resolve = repeater_pkg::TRI_LOW;
    end else begin
      resolve = repeater_pkg::TRI_FLOAT;
    end
  endfunction

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  localparam int SW = 12 + 6;
  logic [SW-1:0] s1_r, s2_r, s1_nxt;
  always_comb begin
    s1_nxt = {eq_select_low_in, eq_select_high_in, deemph_select_low_in,
      deemph_select_high_in, rate_in, idle_control_in,
      register_mode_select_in, detected_gen2_in, input_idle_in,
      power_down_request_in, manual_termination_enable_in,
      termination_request_in};
  end
  always_ff @(posedge clk_in) begin
    s1_r <= s1_nxt;
    s2_r <= s1_r;
  end
  repeater_pkg::tri_t eql, eqh, del, deh, rate, idl;
  logic smb, gen2_det, in_idle, pdr, man, treq;
  always_comb begin
    eql = resolve(s2_r[17:16]); // RULE26
    eqh = resolve(s2_r[15:14]);
    del = resolve(s2_r[13:12]);
    deh = resolve(s2_r[11:10]);
    rate = resolve(s2_r[9:8]);
    idl = resolve(s2_r[7:6]);
    {smb, gen2_det, in_idle, pdr, man, treq} = s2_r[5:0];
  end

  // ==========================================================
  // Equalizer and de-emphasis decode
  // ==========================================================
  repeater_pkg::eq_cfg_t eq_nxt, eq_r;
  repeater_pkg::de_cfg_t de_nxt, de_r;
  logic gen2_r, gen2_nxt, idle_d_r, idle_d_nxt;
  always_comb begin
    eq_nxt = '{`GST_BYPASS, `BST_0}; // RULE1
    if (eqh == repeater_pkg::TRI_HIGH && eql == repeater_pkg::TRI_HIGH) begin
      eq_nxt = '{`GST_ONE, `BST_2}; // RULE2
    end else if (eqh == repeater_pkg::TRI_LOW &&
        eql == repeater_pkg::TRI_LOW) begin
      eq_nxt = '{`GST_TWO, `BST_0}; // RULE3
    end else if (eqh == repeater_pkg::TRI_FLOAT &&
        eql == repeater_pkg::TRI_LOW) begin
      eq_nxt = '{`GST_TWO, `BST_2}; // RULE3
    end else if (eqh == repeater_pkg::TRI_FLOAT &&
        eql == repeater_pkg::TRI_HIGH) begin
      eq_nxt = '{`GST_TWO, `BST_5}; // RULE3
    end else if (eqh == repeater_pkg::TRI_LOW &&
        eql == repeater_pkg::TRI_HIGH) begin
      eq_nxt = '{`GST_TWO, `BST_7}; // RULE3
    end else if (eqh == repeater_pkg::TRI_HIGH &&
        eql == repeater_pkg::TRI_LOW) begin
      eq_nxt = '{`GST_THREE, `BST_1}; // RULE4
    end else if (eqh == repeater_pkg::TRI_LOW &&
        eql == repeater_pkg::TRI_FLOAT) begin
      eq_nxt = '{`GST_THREE, `BST_3}; // RULE5
    end else if (eqh == repeater_pkg::TRI_HIGH &&
        eql == repeater_pkg::TRI_FLOAT) begin
      eq_nxt = '{`GST_THREE, `BST_5}; // RULE5
    end
    // Auto rate latched on each exit from idle
    gen2_nxt = gen2_r;
    if (rate == repeater_pkg::TRI_HIGH) begin
      gen2_nxt = 1'b1;
    end else if (rate == repeater_pkg::TRI_LOW) begin
      gen2_nxt = 1'b0;
    end else if (idle_d_r && !in_idle) begin
      gen2_nxt = gen2_det; // RULE10 RULE24
    end
    idle_d_nxt = in_idle;
    de_nxt.output_swing = `SWING_1000; // RULE7
    de_nxt.pulse_width = gen2_nxt ? `PW_GEN2 : `PW_GEN1; // RULE6
    de_nxt.level = repeater_pkg::DE_RESERVED;
    case ({deh, del})
      {repeater_pkg::TRI_LOW, repeater_pkg::TRI_LOW}: begin
        de_nxt.level = repeater_pkg::DE_0DB; // RULE6
        de_nxt.pulse_width = `PW_NONE;
      end
      {repeater_pkg::TRI_LOW, repeater_pkg::TRI_HIGH}: begin
        de_nxt.level = repeater_pkg::DE_3P5; // RULE7
      end
      {repeater_pkg::TRI_HIGH, repeater_pkg::TRI_LOW}: begin
        de_nxt.level = repeater_pkg::DE_6; // RULE7
      end
      {repeater_pkg::TRI_HIGH, repeater_pkg::TRI_HIGH}: begin
        de_nxt.level = repeater_pkg::DE_6_ENH; // RULE8
      end
      {repeater_pkg::TRI_LOW, repeater_pkg::TRI_FLOAT}: begin
        de_nxt.level = repeater_pkg::DE_9_ENH; // RULE8
      end
      {repeater_pkg::TRI_HIGH, repeater_pkg::TRI_FLOAT}: begin
        de_nxt.level = repeater_pkg::DE_12_ENH; // RULE8
      end
      {repeater_pkg::TRI_FLOAT, repeater_pkg::TRI_LOW}: begin
        de_nxt.level = repeater_pkg::DE_9_ENH; // RULE9
        de_nxt.output_swing = `SWING_1200;
      end
      {repeater_pkg::TRI_FLOAT, repeater_pkg::TRI_HIGH}: begin
        de_nxt.level = repeater_pkg::DE_12_ENH; // RULE9
        de_nxt.output_swing = `SWING_1400;
      end
      default: begin
        de_nxt.level = repeater_pkg::DE_RESERVED; // RULE9
      end
    endcase
    if (smb) begin
      eq_nxt = reg_eq_in; // RULE23
      de_nxt = reg_de_in; // RULE11
      de_nxt.pulse_width = reg_rate_gen2_in ? `PW_GEN2 : `PW_GEN1;
    end
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      eq_r <= '{`GST_BYPASS, `BST_0};
      de_r <= '{repeater_pkg::DE_0DB, `PW_NONE, `SWING_1000};
      gen2_r <= 1'b0;
      idle_d_r <= 1'b1;
    end else begin
      eq_r <= eq_nxt;
      de_r <= de_nxt;
      gen2_r <= gen2_nxt;
      idle_d_r <= idle_d_nxt;
    end
  end

  // ==========================================================
  // Receiver detect state machine
  // ==========================================================
  typedef enum logic [1:0] {ST_WAIT, ST_PROBE, ST_FOUND, ST_STOP} det_t;
  det_t st_r, st_nxt;
  logic [PCW-1:0] tmr_r, tmr_nxt;
  logic [NCW-1:0] cnt_r, cnt_nxt;
  logic [LANES-1:0] found_r, found_nxt, valid;
  logic pdr_d_r, treq_d_r, restart;
  always_comb begin
    valid = load_pos_in & load_neg_in; // RULE22
    restart = (pdr_d_r && !pdr) || (!treq_d_r && treq); // RULE16 RULE21
    st_nxt = st_r;
    tmr_nxt = tmr_r;
    cnt_nxt = cnt_r;
    found_nxt = found_r;
    if (pdr || man || restart) begin
      st_nxt = ST_WAIT; // RULE19
      tmr_nxt = '0;
      cnt_nxt = '0;
      found_nxt = '0;
    end else begin
      case (st_r)
        ST_WAIT: begin
          tmr_nxt = tmr_r + PCW'(1);
          if (tmr_r == PCW'(POLL_CYCLES - 1)) begin
            st_nxt = ST_PROBE; // RULE15
            tmr_nxt = '0;
          end
        end
        ST_PROBE: begin
          found_nxt = valid; // RULE22
          cnt_nxt = cnt_r + NCW'(1);
          if (valid != '0) begin
            st_nxt = ST_FOUND;
          end else if (treq && cnt_r == NCW'(POLL_COUNT - 1)) begin
            st_nxt = ST_STOP; // RULE16
          end else begin
            st_nxt = ST_WAIT;
          end
        end
        ST_FOUND: begin
          st_nxt = ST_FOUND;
        end
        default: begin
          st_nxt = ST_STOP;
        end
      endcase
    end
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_r <= ST_WAIT;
      tmr_r <= '0;
      cnt_r <= '0;
      found_r <= '0;
      pdr_d_r <= 1'b0;
      treq_d_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      tmr_r <= tmr_nxt;
      cnt_r <= cnt_nxt;
      found_r <= found_nxt;
      pdr_d_r <= pdr;
      treq_d_r <= treq;
    end
  end

  // ==========================================================
  // Lane outputs
  // ==========================================================
  logic [LANES-1:0] term_nxt, oen_nxt, oidle_nxt;
  logic probe_nxt, ps_nxt, ide_nxt, rr_nxt;
  always_comb begin
    if (pdr) begin
      term_nxt = '0; // RULE19
      oen_nxt = '0;
    end else if (man) begin
      term_nxt = {LANES{treq}}; // RULE17 RULE18
      oen_nxt = {LANES{treq}};
    end else begin
      term_nxt = found_r; // RULE15
      oen_nxt = found_r;
    end
    ide_nxt = (idl == repeater_pkg::TRI_FLOAT); // RULE12
    if (idl == repeater_pkg::TRI_HIGH) begin
      oidle_nxt = '1; // RULE14
    end else if (idl == repeater_pkg::TRI_FLOAT) begin
      oidle_nxt = {LANES{in_idle}}; // RULE13
    end else begin
      oidle_nxt = '0; // RULE12
    end
    oidle_nxt = oidle_nxt | ~oen_nxt;
    probe_nxt = !pdr && !man && st_nxt == ST_PROBE;
    ps_nxt = pdr;
    rr_nxt = !smb; // RULE25
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      term_50_out <= '0;
      output_enable_out <= '0;
      output_idle_out <= '1;
      idle_detect_enable_out <= 1'b1;
      probe_out <= 1'b0;
      power_save_out <= 1'b0;
      regs_reset_out <= 1'b1;
    end else begin
      term_50_out <= term_nxt;
      output_enable_out <= oen_nxt;
      output_idle_out <= oidle_nxt;
      idle_detect_enable_out <= ide_nxt;
      probe_out <= probe_nxt;
      power_save_out <= ps_nxt;
      regs_reset_out <= rr_nxt;
    end
  end

  for (genvar i = 0; i < LANES; i++) begin : g_lane
    always_ff @(posedge clk_in) begin
      eq_cfg_out[i] <= eq_r; // RULE26
      de_cfg_out[i] <= de_r;
    end
  end
endmodule
`default_nettype wire

// [inc/repeater_defs.svh]
`ifndef REPEATER_DEFS_SVH
`define REPEATER_DEFS_SVH
`define CLK_PERIOD_PS 5000
`define POLL_PERIOD_US 12000
`define POLL_WINDOW_MS 600
`define PD_HOLD_NS 5000
`define GST_BYPASS 2'h0
`define GST_ONE 2'h1
`define GST_TWO 2'h2
`define GST_THREE 2'h3
`define BST_0 3'h0
`define BST_1 3'h1
`define BST_2 3'h2
`define BST_3 3'h3
`define BST_5 3'h5
`define BST_7 3'h7
`define PW_NONE 2'h0
`define PW_GEN1 2'h1
`define PW_GEN2 2'h2
`define SWING_1000 2'h0
`define SWING_1200 2'h1
`define SWING_1400 2'h2
`endif

// [inc/repeater_pkg.sv]
package repeater_pkg;
  typedef enum logic [1:0] {TRI_LOW, TRI_HIGH, TRI_FLOAT} tri_t;
  typedef enum logic [2:0] {
    DE_0DB, DE_3P5, DE_6, DE_6_ENH, DE_9_ENH, DE_12_ENH, DE_RESERVED
  } deemph_t;
  typedef enum logic [1:0] {
    IDLE_PASS, IDLE_AUTO, IDLE_FORCE
  } idle_mode_t;
  typedef struct packed {
    logic [1:0] gain_stage_code;
    logic [2:0] boost_code;
  } eq_cfg_t;
  typedef struct packed {
    deemph_t level;
    logic [1:0] pulse_width;
    logic [1:0] output_swing;
  } de_cfg_t;
  typedef struct packed {
    logic pin_low;
    logic pin_high;
  } tri_pin_t;
endpackage

// [tb/rx_load_model.sv]
`timescale 1ns/1ps
`default_nettype none
// =====
// Downstream receiver load model
module rx_load_model #(
  parameter int LANES = 4
) (
  input wire logic clk_in,
  input wire logic probe_in,
  input wire logic [LANES-1:0] pos_present_in,
  input wire logic [LANES-1:0] neg_present_in,
  output logic [LANES-1:0] load_pos_out,
  output logic [LANES-1:0] load_neg_out
);
  logic [LANES-1:0] noise_r = '0;
  always_ff @(posedge clk_in) begin
    noise_r <= ~noise_r;
  end
  // Sense lines only meaningful in the probe cycle
  always_comb begin
    load_pos_out = probe_in ? pos_present_in : noise_r;
    load_neg_out = probe_in ? neg_present_in : noise_r;
  end
endmodule
`default_nettype wire

// [tb/repeater_lane_config_rx_detect_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
`include "repeater_defs.svh"
// =====
// Port checker
module rx_detect_checker #(
  parameter int LANES = 4
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire repeater_pkg::tri_pin_t eq_select_low_in,
  input wire repeater_pkg::tri_pin_t eq_select_high_in,
  input wire repeater_pkg::tri_pin_t idle_control_in,
  input wire logic register_mode_select_in,
  input wire logic power_down_request_in,
  input wire logic manual_termination_enable_in,
  input wire logic [LANES-1:0] load_pos_in,
  input wire logic [LANES-1:0] load_neg_in,
  input wire repeater_pkg::eq_cfg_t eq_cfg_out [LANES],
  input wire logic [LANES-1:0] output_idle_out,
  input wire logic [LANES-1:0] output_enable_out,
  input wire logic [LANES-1:0] term_50_out,
  input wire logic probe_out,
  input wire logic power_save_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic eq_float;
  logic all_same;
  always_comb begin
    eq_float = (eq_select_low_in.pin_low != eq_select_low_in.pin_high) &&
      (eq_select_high_in.pin_low != eq_select_high_in.pin_high);
    all_same = 1'b1;
    for (int i = 1; i < LANES; i++) begin
      all_same = all_same && (eq_cfg_out[i] == eq_cfg_out[0]);
    end
  end
  a_eq_bypass: assert property (
    (eq_float && !register_mode_select_in) [*6] |->
      eq_cfg_out[0] == {`GST_BYPASS, `BST_0})
    else $error("eq not bypass with floating selects");
  a_lanes_equal: assert property (all_same)
    else $error("lane eq settings differ");
  a_force_idle: assert property (
    (idle_control_in == 2'h3) [*5] |-> output_idle_out == '1)
    else $error("output not idle under forced idle");
  a_off_lane_idle: assert property (
    (output_idle_out | output_enable_out) == '1)
    else $error("disabled lane not idle");
  a_enable_term: assert property (
    output_enable_out == term_50_out)
    else $error("output enable and termination disagree");
  a_pd_off: assert property (
    power_down_request_in [*5] |->
      term_50_out == '0 && power_save_out && !probe_out)
    else $error("power down not honoured");
  a_manual_no_probe: assert property (
    manual_termination_enable_in [*5] |-> !probe_out)
    else $error("probe while manual");
  a_probe_pulse: assert property (probe_out |=> !probe_out)
    else $error("probe longer than one cycle");
  a_probe_load: assert property (
    probe_out && !manual_termination_enable_in && !power_down_request_in |->
      ##2 term_50_out == ($past(term_50_out, 2) |
        ($past(load_pos_in, 2) & $past(load_neg_in, 2))))
    else $error("termination not matching sensed load");
  c_probe: cover property (probe_out);
  c_found: cover property (probe_out ##2 term_50_out != '0);
  c_power_save: cover property (power_save_out);
endmodule
bind repeater_lane_config_rx_detect rx_detect_checker #(.LANES(LANES)) u_chk (
  .clk_in, .rst_in, .eq_select_low_in, .eq_select_high_in, .idle_control_in,
  .register_mode_select_in, .power_down_request_in,
  .manual_termination_enable_in, .load_pos_in, .load_neg_in, .eq_cfg_out,
  .output_idle_out, .output_enable_out, .term_50_out, .probe_out,
  .power_save_out);
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "repeater_defs.svh"
`define CHECK(name, exp, got) begin \
  compares++; \
  if ((got) !== (exp)) begin \
    n_errors++; \
    $display("[FAIL] %s exp %0h got %0h", name, exp, got); \
  end \
end
// =====
// Testbench top
module testbench;
  localparam int POLL = 20;
  localparam int COUNT = 4;
  localparam int WIN = (COUNT + 3) * (POLL + 2);
  localparam logic [1:0] LO = 2'h0;
  localparam logic [1:0] HI = 2'h3;
  localparam logic [1:0] FL = 2'h1;
  // Entries: high pin, low pin, gain stage, boost
  localparam logic [8:0] EQ_TAB [9] = '{{FL, FL, 2'h0, 3'h0},
    {HI, HI, 2'h1, 3'h2}, {LO, LO, 2'h2, 3'h0}, {FL, LO, 2'h2, 3'h2},
    {FL, HI, 2'h2, 3'h5}, {LO, HI, 2'h2, 3'h7}, {HI, LO, 2'h3, 3'h1},
    {LO, FL, 2'h3, 3'h3}, {HI, FL, 2'h3, 3'h5}};
  // Entries: high pin, low pin, level in deemph_t order, swing code
  localparam logic [8:0] DE_TAB [8] = '{{LO, LO, 3'h0, 2'h0},
    {LO, HI, 3'h1, 2'h0}, {HI, LO, 3'h2, 2'h0}, {HI, HI, 3'h3, 2'h0},
    {LO, FL, 3'h4, 2'h0}, {HI, FL, 3'h5, 2'h0}, {FL, LO, 3'h4, 2'h1},
    {FL, HI, 3'h5, 2'h2}};
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  repeater_pkg::tri_pin_t eql = FL, eqh = FL, del = LO, deh = LO;
  repeater_pkg::tri_pin_t rate = LO, idle_ctl = FL;
  repeater_pkg::eq_cfg_t reg_eq = '0;
  repeater_pkg::de_cfg_t reg_de = '0;
  logic regmode = 1'b0, reg_rate = 1'b0, gen2 = 1'b0, in_idle = 1'b0;
  logic pdr = 1'b0, man = 1'b1, req = 1'b1;
  logic [3:0] pos_p = 4'h0, neg_p = 4'h0, lpos, lneg, oidle, oen, term;
  repeater_pkg::eq_cfg_t eq_cfg [4];
  repeater_pkg::de_cfg_t de_cfg [4];
  logic idet, probe, psave, rrst;
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  repeater_lane_config_rx_detect #(.POLL_CYCLES(POLL), .POLL_COUNT(COUNT))
  DUT (
    .clk_in(clk_in), .rst_in(rst_in), .eq_select_low_in(eql),
    .eq_select_high_in(eqh), .deemph_select_low_in(del),
    .deemph_select_high_in(deh), .rate_in(rate), .idle_control_in(idle_ctl),
    .register_mode_select_in(regmode), .reg_eq_in(reg_eq), .reg_de_in(reg_de),
    .reg_rate_gen2_in(reg_rate), .detected_gen2_in(gen2),
    .input_idle_in(in_idle), .power_down_request_in(pdr),
    .manual_termination_enable_in(man), .termination_request_in(req),
    .load_pos_in(lpos), .load_neg_in(lneg), .eq_cfg_out(eq_cfg),
    .de_cfg_out(de_cfg), .output_idle_out(oidle), .output_enable_out(oen),
    .term_50_out(term), .idle_detect_enable_out(idet), .probe_out(probe),
    .power_save_out(psave), .regs_reset_out(rrst));
  rx_load_model u_load (
    .clk_in(clk_in), .probe_in(probe), .pos_present_in(pos_p),
    .neg_present_in(neg_p), .load_pos_out(lpos), .load_neg_out(lneg));
  initial begin
    forever #2.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic count_probes(input int n, output int cnt);
    cnt = 0;
    repeat (n) begin
      tick(1);
      if (probe === 1'b1) cnt++;
    end
  endtask
  task automatic wait_probe(output int gap);
    gap = 0;
    do begin
      tick(1);
      gap++;
    end while (probe !== 1'b1 && gap < 200);
  endtask
  function automatic logic [6:0] de_exp(input logic [8:0] e, input int r);
    logic [1:0] pw;
    pw = r ? `PW_GEN2 : `PW_GEN1;
    if (e[4:2] == 3'h0) pw = `PW_NONE;
    return {e[4:2], pw, e[1:0]};
  endfunction
  task automatic auto_rate(input logic g2, input logic [1:0] pw);
    @(posedge clk_in);
    gen2 <= g2;
    in_idle <= 1'b1;
    tick(6);
    @(posedge clk_in);
    in_idle <= 1'b0;
    tick(8);
    `CHECK("auto rate", pw, de_cfg[2].pulse_width)
  endtask
  task automatic idle_case(input logic [1:0] c, input logic i, logic [3:0] e);
    @(posedge clk_in);
    idle_ctl <= c;
    in_idle <= i;
    tick(8);
    `CHECK("output idle", e, oidle)
  endtask
  task automatic pd_hold();
    @(posedge clk_in);
    pdr <= 1'b1;
    tick(1000);
    `CHECK("pd term", 4'h0, term)
    `CHECK("pd save", 1'b1, psave)
  endtask
  initial begin
    int g;
    int n;
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      @(posedge clk_in);
      eqh <= EQ_TAB[i][8:7];
      eql <= EQ_TAB[i][6:5];
      tick(8);
      `CHECK("eq cfg", EQ_TAB[i][4:0], eq_cfg[3])
    end
    for (int r = 0; r < 2; r++) begin
      for (int i = 0; i < 8; i++) begin
        @(posedge clk_in);
        rate <= r ? HI : LO;
        deh <= DE_TAB[i][8:7];
        del <= DE_TAB[i][6:5];
        tick(8);
        `CHECK("de cfg", de_exp(DE_TAB[i], r), de_cfg[1])
      end
    end
    @(posedge clk_in);
    deh <= FL;
    del <= FL;
    tick(8);
    `CHECK("de reserved", repeater_pkg::DE_RESERVED, de_cfg[0].level)
    @(posedge clk_in);
    rate <= FL;
    deh <= LO;
    del <= HI;
    auto_rate(1'b0, `PW_GEN1);
    auto_rate(1'b1, `PW_GEN2);
    `CHECK("manual term", 4'hf, term)
    idle_case(LO, 1'b1, 4'h0);
    `CHECK("idle detect", 1'b0, idet)
    idle_case(FL, 1'b1, 4'hf);
    `CHECK("idle detect", 1'b1, idet)
    idle_case(FL, 1'b0, 4'h0);
    idle_case(HI, 1'b0, 4'hf);
    idle_case(FL, 1'b0, 4'h0);
    `CHECK("regs reset", 1'b1, rrst)
    @(posedge clk_in);
    reg_eq <= {`GST_THREE, `BST_7};
    reg_de <= {repeater_pkg::DE_6, `PW_GEN1, `SWING_1400};
    reg_rate <= 1'b1;
    regmode <= 1'b1;
    tick(8);
    `CHECK("reg eq", {`GST_THREE, `BST_7}, eq_cfg[1])
    `CHECK("reg de", {repeater_pkg::DE_6, `PW_GEN2, `SWING_1400}, de_cfg[3])
    pd_hold();
    `CHECK("pd keeps regs", 1'b0, rrst)
    @(posedge clk_in);
    regmode <= 1'b0;
    pdr <= 1'b0;
    req <= 1'b0;
    tick(8);
    `CHECK("regs reset", 1'b1, rrst)
    `CHECK("manual off", 4'h0, oen)
    count_probes(3 * POLL, n);
    `CHECK("manual probes", 0, n)
    @(posedge clk_in);
    man <= 1'b0;
    wait_probe(g);
    wait_probe(g);
    `CHECK("probe gap", 1'b1, g >= POLL && g <= POLL + 2)
    count_probes(WIN, n);
    `CHECK("unlimited", 1'b1, n > COUNT + 1)
    @(posedge clk_in);
    pos_p <= 4'h7;
    neg_p <= 4'hb;
    wait_probe(g);
    tick(2);
    `CHECK("found term", 4'h3, term)
    count_probes(3 * POLL, n);
    `CHECK("after found", 0, n)
    @(posedge clk_in);
    pos_p <= 4'h0;
    neg_p <= 4'h0;
    req <= 1'b1;
    pd_hold();
    @(posedge clk_in);
    pdr <= 1'b0;
    count_probes(WIN, n);
    `CHECK("limited", COUNT, n)
    @(posedge clk_in);
    req <= 1'b0;
    tick(4);
    @(posedge clk_in);
    req <= 1'b1;
    count_probes(WIN, n);
    `CHECK("restart", COUNT, n)
    finish_test();
  end
endmodule
`default_nettype wire
